/* File: rtl/pet_defs.svh */
/*
 Constants of the prescaler and event timer: register indices, reset
 values, field positions and timing counts.
 Assumes byte address = 4 * register index on a 32-bit Avalon-MM bus.
*/
`ifndef PET_DEFS_SVH
`define PET_DEFS_SVH

// ****************************************
// register indices (byte address is 4x)
// ****************************************
`define PET_IDX_IRQ_FLAG 6'h02
`define PET_IDX_MODE 6'h09
`define PET_IDX_PRESET_LOW 6'h0a
`define PET_IDX_PRESET_HIGH 6'h0b
`define PET_IDX_EDGE_SELECT 6'h26

// ****************************************
// field positions and widths
// ****************************************
`define PET_MODE_RELOAD_BIT 3
`define PET_IRQ_FLAG_BIT 0
`define PET_DIV_WIDTH 11
`define PET_CNT_WIDTH 8

// ****************************************
// reset values and the counter all-ones value
// ****************************************
`define PET_MODE_RESET 4'h0
`define PET_EDGE_RESET 2'h0
`define PET_PRESET_LOW_RESET 4'h0
`define PET_DIV_RESET 11'h000
`define PET_CNT_ALL_ONES 8'hff

// ****************************************
// timing counts
// ****************************************
// instruction cycles until a mode write takes effect
`define PET_MODE_DELAY_CYC 2'h2

`endif

/* File: rtl/pet_pkg.sv */
/*
 Types of the prescaler and event timer: selector encodings and the
 packed state of the top module.
 Assumes pet_defs.svh is on the include path.
*/
`include "pet_defs.svh"

package pet_pkg;

   // ****************************************
   // selector encodings
   // ****************************************
   typedef enum logic [2:0] {
      pet_clk_2048 = 3'b000,
      pet_clk_512 = 3'b001,
      pet_clk_128 = 3'b010,
      pet_clk_32 = 3'b011,
      pet_clk_8 = 3'b100,
      pet_clk_4 = 3'b101,
      pet_clk_2 = 3'b110,
      pet_clk_event = 3'b111
   } pet_clk_sel_t;

   typedef enum logic [1:0] {
      pet_edge_none = 2'b00,
      pet_edge_fall = 2'b01,
      pet_edge_rise = 2'b10,
      pet_edge_both = 2'b11
   } pet_edge_t;

   // ****************************************
   // whole module state
   // ****************************************
   typedef struct packed {
      logic [10:0] system_clock_divider;
      logic [3:0] event_timer_mode;
      logic [3:0] pend_mode;
      logic [1:0] pend_cnt;
      pet_edge_t event_edge_select;
      logic [3:0] count_preset_low;
      logic [3:0] count_preset_high;
      logic [7:0] event_timer_counter;
      logic [3:0] low_latch;
      logic event_timer_irq_flag;
      logic pin_sync1;
      logic pin_sync2;
      logic pin_prev;
      logic waitreq;
      logic [31:0] rdata;
   } pet_state_t;

endpackage

/* File: rtl/pet_top.sv */
/*
 Prescaler and 8-bit event timer with an Avalon-MM register slave.
 Assumes one 125 MHz clock where one clock equals one instruction cycle,
 an asynchronous event pin, and stop mode driven by logic on this clock.
*/

`include "pet_defs.svh"

module pet_top (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic stop_mode_in,
   input wire logic port_function_select_in,
   input wire logic event_pin_in,
   output logic avs_waitrequest_out,
   output logic [31:0] avs_readdata_out,
   output logic event_timer_irq_flag_out
);
   import pet_pkg::*;

   // ****************************************
   // helper functions
   // ****************************************

   // word address match; low byte address bits must be zero
   function automatic logic addr_hit(input logic [7:0] addr,
                                     input logic [5:0] idx);
      addr_hit = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
   endfunction

   // one-cycle tick as the divider carries out of the chosen tap
   function automatic logic tap_tick(input logic [2:0] sel,
                                     input logic [10:0] div);
      case (sel)
         3'b000: tap_tick = &div[10:0];
         3'b001: tap_tick = &div[8:0];
         3'b010: tap_tick = &div[6:0];
         3'b011: tap_tick = &div[4:0];
         3'b100: tap_tick = &div[2:0];
         3'b101: tap_tick = &div[1:0];
         3'b110: tap_tick = div[0];
         default: tap_tick = 1'b0;
      endcase
   endfunction

   // ****************************************
   // state
   // ****************************************
   pet_state_t s;
   pet_state_t next_s;

   logic req;
   logic take;
   logic accept;
   logic wr_ok;
   logic hit_irq;
   logic hit_mode;
   logic hit_low;
   logic hit_high;
   logic hit_edge;
   logic rise;
   logic fall;
   logic edge_tick;
   logic int_tick;
   logic tick;
   logic event_mode;
   logic [2:0] clk_sel;
   logic [7:0] reload_val;

   // ****************************************
   // bus decode
   // ****************************************
   assign req = avs_read_in | avs_write_in;
   // first cycle of a request: sample read data and read side effects
   assign take = req & s.waitreq;
   // second cycle: waitrequest low, the write takes effect here
   assign accept = req & ~s.waitreq;
   assign wr_ok = accept & avs_write_in & avs_byteenable_in[0];
   assign hit_irq = addr_hit(avs_address_in, `PET_IDX_IRQ_FLAG);
   assign hit_mode = addr_hit(avs_address_in, `PET_IDX_MODE);
   assign hit_low = addr_hit(avs_address_in, `PET_IDX_PRESET_LOW);
   assign hit_high = addr_hit(avs_address_in, `PET_IDX_PRESET_HIGH);
   assign hit_edge = addr_hit(avs_address_in, `PET_IDX_EDGE_SELECT);

   // ****************************************
   // count clock selection
   // ****************************************
   assign clk_sel = s.event_timer_mode[2:0];

   // pin edge detect
   // only the second synchroniser stage and its delayed copy are compared
   assign rise = s.pin_sync2 & ~s.pin_prev;
   assign fall = ~s.pin_sync2 & s.pin_prev;

   assign event_mode = (clk_sel == pet_clk_event) & port_function_select_in;

   always_comb begin
      case (s.event_edge_select)
         pet_edge_none: edge_tick = 1'b0;
         pet_edge_fall: edge_tick = fall;
         pet_edge_rise: edge_tick = rise;
         pet_edge_both: edge_tick = rise | fall;
         default: edge_tick = 1'b0;
      endcase
   end

   // period select
   // no int_tick while stopped, since the divider does not advance then
   assign int_tick = ~stop_mode_in & tap_tick(clk_sel,
                                              s.system_clock_divider);

   assign tick = (clk_sel == pet_clk_event) ? (event_mode & edge_tick)
                                            : int_tick;

   assign reload_val = s.event_timer_mode[`PET_MODE_RELOAD_BIT] ?
                       {s.count_preset_high, s.count_preset_low} : 8'h00;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_s = s;

      if (!stop_mode_in) begin
         next_s.system_clock_divider = s.system_clock_divider + 11'h001;
      end

      next_s.pin_sync1 = event_pin_in;
      next_s.pin_sync2 = s.pin_sync1;
      next_s.pin_prev = s.pin_sync2;

      // ---- bus handshake ----
      // waitrequest drops for exactly one cycle per request
      next_s.waitreq = ~take;

      if (take) begin
         next_s.rdata = 32'h0000_0000;
         if (avs_read_in) begin
            if (hit_irq) begin
               next_s.rdata[`PET_IRQ_FLAG_BIT] = s.event_timer_irq_flag;
            end
            if (hit_high) begin
               next_s.rdata[3:0] = s.event_timer_counter[7:4];
               next_s.low_latch = s.event_timer_counter[3:0];
            end
            if (hit_low) begin
               next_s.rdata[3:0] = s.low_latch;
            end
            // mode and edge select are write-only and read as zero
         end
      end

      // ---- mode register with delayed effect ----
      // two-cycle delay
      if (s.pend_cnt != 2'h0) begin
         next_s.pend_cnt = s.pend_cnt - 2'h1;
         if (s.pend_cnt == 2'h1) begin
            next_s.event_timer_mode = s.pend_mode;
         end
      end
      // mode write
      // a new write restarts the delay and replaces a pending value
      if (wr_ok && hit_mode) begin
         next_s.pend_mode = avs_writedata_in[3:0];
         next_s.pend_cnt = `PET_MODE_DELAY_CYC;
      end

      if (wr_ok && hit_edge) begin
         next_s.event_edge_select = pet_edge_t'(avs_writedata_in[1:0]);
      end

      if (wr_ok && hit_low) begin
         next_s.count_preset_low = avs_writedata_in[3:0];
      end

      // ---- counter ----
      if (wr_ok && hit_high) begin
         // stored low nibble reused
         // a software load wins over a tick in the same cycle
         next_s.count_preset_high = avs_writedata_in[3:0];
         next_s.event_timer_counter = {avs_writedata_in[3:0],
                                       s.count_preset_low};
      end else if (tick) begin
         if (s.event_timer_counter == `PET_CNT_ALL_ONES) begin
            next_s.event_timer_counter = reload_val;
         end else begin
            next_s.event_timer_counter = s.event_timer_counter + 8'h01;
         end
      end

      // ---- interrupt request flag ----
      // software clear
      if (wr_ok && hit_irq && avs_writedata_in[`PET_IRQ_FLAG_BIT]) begin
         next_s.event_timer_irq_flag = 1'b0;
      end
      if (!(wr_ok && hit_high) && tick &&
          (s.event_timer_counter == `PET_CNT_ALL_ONES)) begin
         next_s.event_timer_irq_flag = 1'b1;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         s.system_clock_divider <= `PET_DIV_RESET;
         s.event_timer_mode <= `PET_MODE_RESET;
         s.pend_mode <= `PET_MODE_RESET;
         s.pend_cnt <= 2'h0;
         s.event_edge_select <= pet_edge_none;
         s.count_preset_low <= `PET_PRESET_LOW_RESET;
         // high nibble and counter have no documented value; zero is used
         s.count_preset_high <= 4'h0;
         s.event_timer_counter <= 8'h00;
         s.low_latch <= 4'h0;
         s.event_timer_irq_flag <= 1'b0;
         s.pin_sync1 <= 1'b0;
         s.pin_sync2 <= 1'b0;
         s.pin_prev <= 1'b0;
         s.waitreq <= 1'b1;
         s.rdata <= 32'h0000_0000;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign avs_waitrequest_out = s.waitreq;
   assign avs_readdata_out = s.rdata;
   assign event_timer_irq_flag_out = s.event_timer_irq_flag;

   // the event source must keep more than two cycles from a falling to
   // the next rising edge; the three-flop path adds a fixed latency of
   // about three cycles but drops nothing that meets that spacing

endmodule

/* File: test/pet_event_src.sv */
/*
 Event source model: sends a burst of pulses on the event pin.
 Assumes go_in is raised for one cycle by the bench.
*/
module pet_event_src #(parameter int HALF = 4) (
   input wire logic core_clk_in,
   input wire logic go_in,
   input wire logic [3:0] pulses_in,
   output logic event_pin_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // one process owns the pin, so it has a single driver
   initial begin
      event_pin_out = 1'b0;
      forever begin
         @(posedge core_clk_in);
         if (go_in === 1'b1) begin
            repeat (pulses_in) begin
               repeat (HALF) @(posedge core_clk_in);
               event_pin_out <= 1'b1;
               repeat (HALF) @(posedge core_clk_in);
               event_pin_out <= 1'b0;
            end
         end
      end
   end
endmodule

/* File: test/pet_top_sva.sv */
/*
 Checker of the register bus answer and the irq flag of pet_top.
 Assumes it is bound onto pet_top and sees only its ports.
*/
// ***********************
// bus and flag checks
// ***********************
module pet_top_sva (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic avs_waitrequest_out,
   input wire logic [31:0] avs_readdata_out,
   input wire logic event_timer_irq_flag_out
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (reset_in);
   logic rd_done;
   logic mapped;
   assign rd_done = avs_read_in && !avs_waitrequest_out;
   assign mapped = avs_address_in inside {8'h08, 8'h28, 8'h2c};
   AST_WAIT_ONE: assert property ((avs_read_in || avs_write_in) &&
      avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("request not answered after one wait cycle");
   AST_WAIT_PULSE: assert property (!avs_waitrequest_out |=>
      avs_waitrequest_out) else $error("waitrequest low too long");
   AST_WAIT_IDLE: assert property (!avs_read_in && !avs_write_in |=>
      avs_waitrequest_out) else $error("answer without a request");
   AST_RDATA_TOP: assert property (rd_done |->
      avs_readdata_out[31:4] == 28'h0) else $error("read upper bits set");
   AST_UNMAPPED_ZERO: assert property (rd_done && !mapped |->
      avs_readdata_out == 32'h0) else $error("write-only read not zero");
   AST_IRQ_READ: assert property (rd_done && avs_address_in == 8'h08 |->
      avs_readdata_out[0] == $past(event_timer_irq_flag_out))
      else $error("flag read differs from flag");
   AST_IRQ_CLEAR: assert property ($fell(event_timer_irq_flag_out) |->
      $past(avs_write_in && !avs_waitrequest_out &&
      avs_address_in == 8'h08 && avs_writedata_in[0] &&
      avs_byteenable_in[0])) else $error("flag cleared without write");
   AST_RDATA_HOLD: assert property (!$past(avs_read_in || avs_write_in)
      |-> $stable(avs_readdata_out)) else $error("read data moved");
endmodule
bind pet_top pet_top_sva chk_u (.core_clk_in, .reset_in, .avs_address_in,
   .avs_read_in, .avs_write_in, .avs_byteenable_in, .avs_writedata_in,
   .avs_waitrequest_out, .avs_readdata_out, .event_timer_irq_flag_out);

/* File: test/test_pet_top.sv */
/*
 Self-checking bench of pet_top: register tasks, rate table, events.
 Assumes pet_event_src drives the event pin.
*/
module test_pet_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_in = 0;
   logic reset_in = 1;
   logic [7:0] addr = 0;
   logic rd_r = 0, wr_r = 0, stop = 1, route = 0, go = 0;
   logic pin, waitreq, irq;
   logic [31:0] wdata = 0;
   logic [31:0] rdata;
   int failures = 0;
   int samples_checked = 0;
   integer seed = 32'h641c;
   logic [31:0] exp_q[$];
   int per[7] = '{2048, 512, 128, 32, 8, 4, 2};
   logic [1:0] eds[5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h3};
   logic [7:0] evx[5] = '{8'h03, 8'h03, 8'h06, 8'h00, 8'h00};

   pet_top dut_u (.core_clk_in(core_clk_in), .reset_in(reset_in),
      .avs_address_in(addr), .avs_read_in(rd_r), .avs_write_in(wr_r),
      .avs_byteenable_in(4'hf), .avs_writedata_in(wdata),
      .stop_mode_in(stop), .port_function_select_in(route),
      .event_pin_in(pin), .avs_waitrequest_out(waitreq),
      .avs_readdata_out(rdata), .event_timer_irq_flag_out(irq));
   pet_event_src src_u (.core_clk_in(core_clk_in), .go_in(go),
      .pulses_in(4'h3), .event_pin_out(pin));
   initial forever #4 core_clk_in = ~core_clk_in;
   task automatic conclude;
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check_word(input logic [31:0] got, input logic [31:0] e);
      samples_checked++;
      if (got !== e) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask
   // waits for the answer however long it takes; only the watchdog ends it
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      @(posedge core_clk_in);
      addr <= a;
      rd_r <= !w;
      wr_r <= w;
      wdata <= d;
      do begin
         @(posedge core_clk_in);
      end while (waitreq !== 1'b0);
      rd_r <= 1'b0;
      wr_r <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(a, 1'b0, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic load(input logic [7:0] v);
      wr(8'h28, {28'h0, v[3:0]});
      wr(8'h2c, {28'h0, v[7:4]});
   endtask
   task automatic cnt(input logic [7:0] e);
      rd(8'h2c, {28'h0, e[7:4]});
      rd(8'h28, {28'h0, e[3:0]});
   endtask
   always @(posedge core_clk_in) begin
      if (rd_r && waitreq === 1'b0) begin
         if (exp_q.size() == 0) failures++;
         else check_word(rdata, exp_q.pop_front());
      end
   end
   initial begin
      repeat (40000) @(posedge core_clk_in);
      failures++;
      conclude;
   end
   initial begin
      logic [7:0] v;
      logic [3:0] h;
      logic r;
      int i;
      repeat (3) @(posedge core_clk_in);
      reset_in <= 1'b0;
      rd(8'h24, 32'h0);
      rd(8'h98, 32'h0);
      rd(8'h30, 32'h0);
      rd(8'h29, 32'h0);
      cnt(8'h00);
      wr(8'h2c, 32'h3);
      cnt(8'h30);
      v = 8'($random(seed));
      h = ~v[7:4];
      wr(8'h28, {28'h0, v[3:0]});
      cnt(8'h30);
      wr(8'h2c, {28'h0, v[7:4]});
      cnt(v);
      wr(8'h2c, {28'h0, h});
      cnt({h, v[3:0]});
      rd(8'h2c, {28'h0, h});
      load(8'h5a);
      rd(8'h28, {28'h0, v[3:0]});
      for (i = 0; i < 7; i++) begin
         r = 1'($random(seed));
         wr(8'h24, {28'h0, r, i[2:0]});
         // stop keeps the count frozen while setting up
         repeat (4) @(posedge core_clk_in);
         load(8'hfe);
         @(posedge core_clk_in);
         stop <= 1'b0;
         repeat (per[i] * 3) @(posedge core_clk_in);
         stop <= 1'b1;
         cnt(r ? 8'hff : 8'h01);
         check_word({31'h0, irq}, 32'h1);
         rd(8'h08, 32'h1);
         wr(8'h08, 32'h1);
         rd(8'h08, 32'h0);
      end
      wr(8'h24, 32'h7);
      route <= 1'b1;
      for (i = 0; i < 5; i++) begin
         if (i == 4) route <= 1'b0;
         wr(8'h98, {30'h0, eds[i]});
         load(8'h00);
         go <= 1'b1;
         @(posedge core_clk_in);
         go <= 1'b0;
         repeat (40) @(posedge core_clk_in);
         cnt(evx[i]);
      end
      conclude;
   end
endmodule
